//--- common/commission_consts.vh
// constants for the local commissioning controller
`ifndef COMMISSION_CONSTS_VH
`define COMMISSION_CONSTS_VH
`define CLK_HZ          100000000
`define HOLD_ARM_MS     2000
`define HOLD_MAX_MS     7000
`define BLINK_MS        250
`define TUNE_MIN_S      180
`define TUNE_MAX_S      600
// state codes
`define ST_IDLE         3'h0
`define ST_FS_HOLD      3'h1
`define ST_FS_RUN       3'h2
`define ST_OS_HOLD      3'h3
`define ST_OS_ADJ       3'h4
`define ST_OS_SAVE      3'h5
`define ST_AT_HOLD      3'h6
`define ST_AT_RUN       3'h7
// apb register offsets
`define REG_CTRL        12'h000
`define REG_STATUS      12'h004
`define REG_TUNE        12'h008
`define REG_STOP        12'h00c
// ctrl bits
`define CTRL_FS_DONE    0
`define CTRL_AT_DONE    1
`endif

//--- hdl/local_commissioning_ui.v
// local commissioning controller: buttons, selector, leds, apb registers
// Notes on behaviour
// - selector 0-7 means air opens valve, 8-f air closes valve for find stops.
// - find stops led on after 2 s hold; start only if released before 7 s.
// - while find stops runs, commissioning state and led 1 blinks.
// - find stops or auto tune completion returns to normal mode by itself.
// - cancel during find stops aborts, led 1 off, normal mode, stops kept.
// - upper stop held 2 to 7 s lights led 2; after release led 2 flashes.
// - second upper stop hold over 2 s stores position, led off, normal.
// - cancel during open stop adjust aborts, led off, normal, nothing stored.
// - selector 1-7 and 9-f pick presets by size; 0 and 8 for auto tune.
// - a preset on the selector takes effect at once; after auto tune, reselecting the preset still in tune_preset is ignored.
// - auto tune strokes in steps for pid and takes three to ten minutes.
// - completed auto tune replaces any preset tuning.
// - auto tune held 2 to 7 s lights led 3; on release blinks while tuning.
// - cancel during auto tune aborts, led 3 off, normal, tuning kept.
//
// Implementation choices: the register addresses and the APB register port.
`include "commission_consts.vh"
`timescale 1ns/1ns
`default_nettype none

module local_commissioning_ui #(
   parameter HOLD_ARM_CYC = `HOLD_ARM_MS * (`CLK_HZ / 1000),
   parameter HOLD_MAX_CYC = `HOLD_MAX_MS * (`CLK_HZ / 1000),
   parameter BLINK_CYC    = `BLINK_MS * (`CLK_HZ / 1000),
   parameter SEC_CYC      = `CLK_HZ,
   parameter TUNE_MIN_CYC = `TUNE_MIN_S,
   parameter TUNE_MAX_CYC = `TUNE_MAX_S
) (
   input  wire        clock,
   input  wire        arst_n,
   input  wire        find_stops_btn,
   input  wire        upper_stop_btn,
   input  wire        auto_tune_btn,
   input  wire        cancel_btn,
   input  wire [3:0]  selector,
   input  wire [15:0] valve_position,
   output reg         led1,
   output reg         led2,
   output reg         led3,
   output reg         air_closes_valve,
   output reg         commissioning,
   output reg         find_stops_run,
   output reg         auto_tune_run,
   output reg  [3:0]  tune_preset,
   output reg         tune_from_auto,
   output reg  [15:0] open_stop,
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr
);

   ////////////////////////////////////////////////////////////////////////////
   // reset release and pin synchronisers
   reg       rst_m_q;
   reg       rst_q;
   reg [7:0] pin_m_q;
   reg [7:0] pin_q;
   wire      rst_n = rst_q;

   // two-stage reset release
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) begin
         rst_m_q <= 1'b0;
         rst_q   <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_q   <= rst_m_q;
      end
   end

   // two flops on every button and selector input
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pin_m_q <= 8'h00;
         pin_q   <= 8'h00;
      end else begin
         pin_m_q <= {selector, cancel_btn, auto_tune_btn, upper_stop_btn, find_stops_btn};
         pin_q   <= pin_m_q;
      end
   end

   wire       fs_b  = pin_q[0];
   wire       us_b  = pin_q[1];
   wire       at_b  = pin_q[2];
   wire       cn_b  = pin_q[3];
   wire [3:0] sel_s = pin_q[7:4];

   ////////////////////////////////////////////////////////////////////////////
   // apb registers
   reg        fs_done_q;
   reg        at_done_q;
   // sequencer state, read back in the status word
   reg [2:0]  state_q;
   wire       apb_acc = psel & penable & pready;
   wire       apb_wr  = apb_acc & pwrite;
   wire       map_hit = (paddr == `REG_CTRL) | (paddr == `REG_STATUS) |
                        (paddr == `REG_TUNE) | (paddr == `REG_STOP);

   // no wait state, answer in the first access cycle; ctrl write pulses process-done inputs
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         pready    <= 1'b0;
         pslverr   <= 1'b0;
         prdata    <= 32'h00000000;
         fs_done_q <= 1'b0;
         at_done_q <= 1'b0;
      end else begin
         pready    <= psel & ~penable;
         pslverr   <= psel & ~penable & ~map_hit;
         fs_done_q <= apb_wr & (paddr == `REG_CTRL) & pwdata[`CTRL_FS_DONE];
         at_done_q <= apb_wr & (paddr == `REG_CTRL) & pwdata[`CTRL_AT_DONE];
         if (psel & ~penable & ~pwrite) begin
            case (paddr)
               `REG_STATUS: prdata <= {22'h000000, tune_from_auto, commissioning,
                                       air_closes_valve, led3, led2, led1,
                                       1'b0, state_q};
               `REG_TUNE:   prdata <= {28'h0000000, tune_preset};
               `REG_STOP:   prdata <= {16'h0000, open_stop};
               default:     prdata <= 32'h00000000;
            endcase
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // hold timer, blink and tune watchdog
   reg [31:0] hold_q;
   reg [31:0] blink_q;
   reg        blink_on_q;
   reg [31:0] sec_q;
   reg [15:0] tune_s_q;
   wire       hold_arm  = (hold_q >= HOLD_ARM_CYC);
   wire       hold_over = (hold_q >= HOLD_MAX_CYC);
   // first cycle of a press: no command button was down a cycle ago
   wire       press_new = (hold_q == 32'h00000000);
   wire       tune_done = at_done_q & (tune_s_q >= TUNE_MIN_CYC) |
                          (tune_s_q >= TUNE_MAX_CYC);

   // timers
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         hold_q     <= 32'h00000000;
         blink_q    <= 32'h00000000;
         blink_on_q <= 1'b0;
         sec_q      <= 32'h00000000;
         tune_s_q   <= 16'h0000;
      end else begin
         // count while a command button is down; stop at the ceiling so a
         // very long hold cannot wrap round and look armed again
         if (!(fs_b | us_b | at_b)) begin
            hold_q <= 32'h00000000;
         end else if (!hold_over) begin
            hold_q <= hold_q + 32'h00000001;
         end
         if (blink_q >= BLINK_CYC - 1) begin
            blink_q    <= 32'h00000000;
            blink_on_q <= ~blink_on_q;
         end else begin
            blink_q <= blink_q + 32'h00000001;
         end
         if (state_q != `ST_AT_RUN) begin
            sec_q    <= 32'h00000000;
            tune_s_q <= 16'h0000;
         end else if (sec_q >= SEC_CYC - 1) begin
            sec_q    <= 32'h00000000;
            tune_s_q <= tune_s_q + 16'h0001;
         end else begin
            sec_q <= sec_q + 32'h00000001;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // commissioning sequencer: hold states arm on a long press and act on
   // release; run states wait for the done strobe, the tune watchdog or
   // cancel, and cancel always wins
   reg [2:0] state_d;

   // next state; a command is taken only on the first cycle of a press, so a
   // button still held after a procedure ends cannot start another one
   always @* begin
      state_d = state_q;
      case (state_q)
         `ST_IDLE: begin
            if (press_new) begin
               if (fs_b) begin
                  state_d = `ST_FS_HOLD;
               end else if (us_b) begin
                  state_d = `ST_OS_HOLD;
               end else if (at_b) begin
                  state_d = `ST_AT_HOLD;
               end
            end
         end
         `ST_FS_HOLD: begin
            if (!fs_b) begin
               if (hold_arm && !hold_over) begin
                  state_d = `ST_FS_RUN;
               end else begin
                  state_d = `ST_IDLE;
               end
            end
         end
         `ST_FS_RUN: begin
            if (cn_b) begin
               state_d = `ST_IDLE;
            end else if (fs_done_q) begin
               state_d = `ST_IDLE;
            end
         end
         `ST_OS_HOLD: begin
            if (!us_b) begin
               if (hold_arm && !hold_over) begin
                  state_d = `ST_OS_ADJ;
               end else begin
                  state_d = `ST_IDLE;
               end
            end
         end
         `ST_OS_ADJ: begin
            if (cn_b) begin
               state_d = `ST_IDLE;
            end else if (us_b) begin
               state_d = `ST_OS_SAVE;
            end
         end
         `ST_OS_SAVE: begin
            if (cn_b) begin
               state_d = `ST_IDLE;
            end else if (hold_arm) begin
               state_d = `ST_IDLE;
            end else if (!us_b) begin
               state_d = `ST_OS_ADJ;
            end
         end
         `ST_AT_HOLD: begin
            if (!at_b) begin
               if (hold_arm && !hold_over) begin
                  state_d = `ST_AT_RUN;
               end else begin
                  state_d = `ST_IDLE;
               end
            end
         end
         `ST_AT_RUN: begin
            if (cn_b) begin
               state_d = `ST_IDLE;
            end else if (tune_done) begin
               state_d = `ST_IDLE;
            end
         end
         default: begin
            state_d = `ST_IDLE;
         end
      endcase
   end

   // indicator levels for the coming state: steady while a hold is armed,
   // blinking while a procedure runs, dark otherwise
   reg  led1_d;
   reg  led2_d;
   reg  led3_d;
   wire armed = hold_arm & ~hold_over;

   always @* begin
      led1_d = 1'b0;
      led2_d = 1'b0;
      led3_d = 1'b0;
      case (state_d)
         `ST_FS_HOLD: begin
            led1_d = armed;
         end
         `ST_FS_RUN: begin
            led1_d = blink_on_q;
         end
         `ST_OS_HOLD: begin
            led2_d = armed;
         end
         `ST_OS_ADJ, `ST_OS_SAVE: begin
            led2_d = blink_on_q;
         end
         `ST_AT_HOLD: begin
            led3_d = armed;
         end
         `ST_AT_RUN: begin
            led3_d = blink_on_q;
         end
         default: begin
            led1_d = 1'b0;
         end
      endcase
   end

   // state, leds and stored results
   always @(posedge clock or negedge rst_n) begin
      if (!rst_n) begin
         state_q          <= `ST_IDLE;
         led1             <= 1'b0;
         led2             <= 1'b0;
         led3             <= 1'b0;
         air_closes_valve <= 1'b0;
         commissioning    <= 1'b0;
         find_stops_run   <= 1'b0;
         auto_tune_run    <= 1'b0;
         tune_preset      <= 4'h0;
         tune_from_auto   <= 1'b0;
         open_stop        <= 16'h0000;
      end else begin
         state_q <= state_d;
         // indicators straight from flops
         led1 <= led1_d;
         led2 <= led2_d;
         led3 <= led3_d;
         commissioning  <= (state_d == `ST_FS_RUN) | (state_d == `ST_AT_RUN);
         find_stops_run <= (state_d == `ST_FS_RUN);
         auto_tune_run  <= (state_d == `ST_AT_RUN);
         // air action latched when find stops starts
         if (state_q == `ST_FS_HOLD && state_d == `ST_FS_RUN)
            air_closes_valve <= sel_s[3];
         // new open stop only on a completed second hold
         if (state_q == `ST_OS_SAVE && state_d == `ST_IDLE && !cn_b)
            open_stop <= valve_position;
         // preset follows selector at once; 0 and 8 leave tuning alone
         if (sel_s[2:0] != 3'h0 && sel_s != tune_preset) begin
            tune_preset    <= sel_s;
            tune_from_auto <= 1'b0;
         end else if (state_q == `ST_AT_RUN && state_d == `ST_IDLE && !cn_b) begin
            tune_from_auto <= 1'b1;
         end
      end
   end

endmodule
`default_nettype wire

//--- tb/commissioning_props.sv
// concurrent checks on the commissioning controller ports
`timescale 1ns/1ns
`default_nettype none
module commissioning_props #(
   parameter BLINK_CYC    = 4,
   parameter SEC_CYC      = 10,
   parameter TUNE_MIN_CYC = 2,
   parameter TUNE_MAX_CYC = 6
) (
   input wire logic       clock,
   input wire logic       arst_n,
   input wire logic       cancel_btn,
   input wire logic [3:0] selector,
   input wire logic       led1,
   input wire logic       led3,
   input wire logic       air_closes_valve,
   input wire logic       commissioning,
   input wire logic       find_stops_run,
   input wire logic       auto_tune_run,
   input wire logic [3:0] tune_preset,
   input wire logic       tune_from_auto,
   input wire logic       psel,
   input wire logic       penable,
   input wire logic       pready,
   input wire logic       pslverr
);
   localparam int BLK = BLINK_CYC + 1;
   default clocking cb @(posedge clock); endclocking
   default disable iff (!arst_n);
   int run_cnt;
   ////////////////////////////////////////
   // length of the current auto tune run
   always @(posedge clock or negedge arst_n) begin
      if (!arst_n) run_cnt <= 0;
      else run_cnt <= auto_tune_run ? run_cnt + 1 : 0;
   end
   sequence preset_moved; $changed(selector) && selector[2:0] != 3'h0; endsequence
   sequence preset_held; $stable(selector)[*5]; endsequence
   a_comm_tracks: assert property (commissioning == (find_stops_run || auto_tune_run))
      else $error("commissioning flag off its process");
   a_led1_blink: assert property (find_stops_run && led1 |-> ##[1:BLK] (!led1 || !find_stops_run))
      else $error("led1 not blinking");
   a_led1_off: assert property ($fell(find_stops_run) |-> ##[0:2] !led1)
      else $error("led1 lit after find stops");
   a_fs_cancel: assert property (cancel_btn && find_stops_run |-> ##[1:6] !find_stops_run)
      else $error("cancel ignored in find stops");
   a_at_cancel: assert property (cancel_btn && auto_tune_run |-> ##[1:6] (!auto_tune_run && !led3))
      else $error("cancel ignored in auto tune");
   a_led3_blink: assert property (auto_tune_run && led3 |-> ##[1:BLK] (!led3 || !auto_tune_run))
      else $error("led3 not blinking");
   a_tune_bound: assert property (run_cnt <= (TUNE_MAX_CYC + 1) * SEC_CYC)
      else $error("auto tune overran");
   a_auto_source: assert property ($rose(tune_from_auto) |-> $past(auto_tune_run) && $past(run_cnt) >= TUNE_MIN_CYC * SEC_CYC - 2)
      else $error("auto tuning without a full run");
   a_fs_polarity: assert property ($rose(find_stops_run) |-> air_closes_valve == selector[3])
      else $error("air action wrong");
   a_preset_now: assert property (preset_moved ##1 preset_held |-> tune_preset == selector)
      else $error("preset not applied");
   a_apb_answer: assert property (psel && !penable |=> pready ##1 (!pready && !pslverr))
      else $error("apb answer timing");
   a_err_ready: assert property (pslverr |-> pready)
      else $error("apb error without ready");
endmodule
bind local_commissioning_ui commissioning_props #(.BLINK_CYC(BLINK_CYC), .SEC_CYC(SEC_CYC),
   .TUNE_MIN_CYC(TUNE_MIN_CYC), .TUNE_MAX_CYC(TUNE_MAX_CYC)) u_props (.clock, .arst_n,
   .cancel_btn, .selector, .led1, .led3, .air_closes_valve, .commissioning, .find_stops_run,
   .auto_tune_run, .tune_preset, .tune_from_auto, .psel, .penable, .pready, .pslverr);
`default_nettype wire

//--- tb/operator_panel.sv
// operator model: pushbuttons, selector switch, valve position
`timescale 1ns/1ns
`default_nettype none
module operator_panel (
   input  wire logic        clock,
   output var  logic [3:0]  btn,
   output var  logic [3:0]  selector,
   output var  logic [15:0] valve_position
);
   // all idle at power up
   initial begin
      btn = 4'h0;
      selector = 4'h0;
      valve_position = 16'h0000;
   end
   // hold button b (find, upper, tune, cancel) n cycles, then settle
   task automatic press(input int b, input int n);
      btn[b] <= 1'b1;
      repeat (n) @(posedge clock);
      btn[b] <= 1'b0;
      repeat (8) @(posedge clock);
   endtask
endmodule
`default_nettype wire

//--- tb/local_commissioning_ui_tb.sv
// self-checking bench for the local commissioning controller
`include "commission_consts.vh"
`timescale 1ns/1ns
`default_nettype none
module local_commissioning_ui_tb;
   logic        clock, arst_n, psel, penable, pwrite, pready, pslverr;
   logic        led1, led2, led3, air_closes_valve, commissioning;
   logic        find_stops_run, auto_tune_run, tune_from_auto;
   logic [3:0]  btn, selector, tune_preset, p;
   logic [11:0] paddr;
   logic [15:0] valve_position, open_stop, stop;
   logic [31:0] pwdata, prdata;
   logic [65:0] q[$], n;
   int          errors = 0, cmp_count = 0, cyc = 0, seed = 32'h1eb1;
   operator_panel u_operator_panel (.clock, .btn, .selector, .valve_position);
   local_commissioning_ui #(.HOLD_ARM_CYC(20), .HOLD_MAX_CYC(70), .BLINK_CYC(4), .SEC_CYC(10),
      .TUNE_MIN_CYC(2)) u_local_commissioning_ui (.clock, .arst_n,
      .find_stops_btn(btn[0]), .upper_stop_btn(btn[1]), .auto_tune_btn(btn[2]),
      .cancel_btn(btn[3]), .selector, .valve_position, .led1, .led2, .led3, .air_closes_valve,
      .commissioning, .find_stops_run, .auto_tune_run, .tune_preset, .tune_from_auto,
      .open_stop, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr);
   ////////////////////////////////////////
   task close_out;
      if (errors == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   task chk(input string s, input logic [32:0] e, g, m);
      cmp_count++;
      if ((g & m) !== (e & m)) begin
         errors++;
         $display("unexpected %s exp %h got %h", s, e & m, g & m);
      end
   endtask
   // apb transfer; expectation noted before the request goes out
   task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d,
                      input logic [32:0] e, m);
      q.push_back({e, m});
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      do @(posedge clock); while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clock);
   endtask
   task automatic st(input logic [31:0] e, m);
      bus(1'b0, `REG_STATUS, 32'h0, {1'b0, e}, {1'b1, m});
   endtask
   ////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   // take the oldest note at each completed transfer
   always @(posedge clock) begin
      if (psel && penable && pready === 1'b1) begin
         n = q.pop_front();
         chk("apb answer", n[65:33], {pslverr, prdata}, n[32:0]);
      end
   end
   // cut a hang short
   always @(posedge clock) begin
      cyc++;
      if (cyc == 20000) begin
         errors++;
         close_out;
      end
   end
   initial begin
      {psel, penable, pwrite, paddr, pwdata, arst_n} = '0;
      repeat (16) @(posedge clock);
      arst_n <= 1'b1;
      repeat (4) @(posedge clock);
      st(32'h0, 32'h3f7);
      bus(1'b0, 12'h0f0, 32'h0, 33'h1_0000_0000, '1);
      repeat (4) begin
         p = $random(seed);
         p[0] = p[0] | (p[2:1] == 2'h0);
         u_operator_panel.selector <= p;
         repeat (6) @(posedge clock);
         bus(1'b0, `REG_TUNE, 32'h0, {29'h0, p}, 33'h1_0000_000f);
      end
      u_operator_panel.selector <= 4'h8;
      u_operator_panel.press(0, 30);
      st(32'h182, 32'h387);
      bus(1'b1, `REG_CTRL, $random(seed) & 32'hfffffffc | 32'h1, 33'h0, 33'h1_0000_0000);
      st(32'h080, 32'h3f7);
      u_operator_panel.press(0, 30);
      u_operator_panel.press(3, 2);
      st(32'h080, 32'h3f7);
      u_operator_panel.press(0, 80);
      st(32'h080, 32'h3f7);
      stop = $random(seed);
      u_operator_panel.valve_position <= stop;
      u_operator_panel.press(1, 30);
      st(32'h084, 32'h387);
      u_operator_panel.press(1, 25);
      bus(1'b0, `REG_STOP, 32'h0, {17'h0, stop}, 33'h1_0000_ffff);
      st(32'h080, 32'h3f7);
      u_operator_panel.press(1, 30);
      u_operator_panel.valve_position <= ~stop;
      u_operator_panel.press(3, 2);
      st(32'h080, 32'h3f7);
      bus(1'b0, `REG_STOP, 32'h0, {17'h0, stop}, 33'h1_0000_ffff);
      u_operator_panel.selector <= 4'h0;
      u_operator_panel.press(2, 30);
      st(32'h187, 32'h387);
      repeat (25) @(posedge clock);
      bus(1'b1, `REG_CTRL, $random(seed) & 32'hfffffffc | 32'h2, 33'h0, 33'h1_0000_0000);
      st(32'h280, 32'h3f7);
      u_operator_panel.selector <= 4'h8;
      u_operator_panel.press(2, 30);
      u_operator_panel.press(3, 2);
      st(32'h280, 32'h3f7);
      bus(1'b0, `REG_TUNE, 32'h0, {29'h0, p}, 33'h1_0000_000f);
      u_operator_panel.press(2, 30);
      repeat (`TUNE_MAX_S * 10 + 20) @(posedge clock);
      st(32'h080, 32'h177);
      close_out;
   end
endmodule
`default_nettype wire
